//--- pis_pkg.sv
// Constants for the port-pin interrupt source selector: register map, field positions and reset values.
// Assumes a 32-bit AHB-Lite slave port on a single 10 MHz system clock.
//
// What this block does
// RULE_01: special mux bit 7 picks comparator for line 7
// RULE_02: special mux bit 0 picks debug for line 0
// RULE_03: special mux bits 6..1 read zero, write zero
// RULE_04: per-line select, port A or port D pin
// RULE_05: per-line edge, falling when 0, rising when 1
// RULE_06: four lines pick DMA or port C; upper reserved
// RULE_07: eight edge-selectable lines plus four dual-edge lines
// RULE_08: each request has one of three priority levels
// RULE_09: software can set any request pending
// RULE_10: system exceptions are never masked
// RULE_11: polled mode ignores enables and priorities; flags readable
// RULE_12: line 7 vector 0030H, line 0 004CH, comparator both edges
// RULE_13: port C lines use 0060H..006CH, both edges
// RULE_14: pins synchronised, each edge sets pending once
package pis_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_SPECIAL_MUX = 32'h00FF_E10C;
  localparam logic [31:0] IDX_AD_SELECT = 32'h00FF_E10E;
  localparam logic [31:0] IDX_EDGE_POL = 32'h00FF_E10F;
  localparam logic [31:0] IDX_CD_SELECT = 32'h00FF_E12E;
  localparam logic [31:0] IDX_STATUS = 32'h00FF_E140;
  localparam logic [31:0] IDX_CLEAR = 32'h00FF_E141;
  localparam logic [31:0] IDX_ENABLE = 32'h00FF_E142;
  localparam logic [31:0] IDX_SOFT_SET = 32'h00FF_E143;
  localparam logic [31:0] IDX_PRIORITY = 32'h00FF_E144;
  localparam logic [31:0] IDX_CONTROL = 32'h00FF_E145;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int NUM_AD = 8;
  localparam int NUM_CD = 4;
  localparam int NUM_LINES = 12;
  localparam int NUM_SYNC = 21;
  localparam int SYNC_PD_LSB = 8;
  localparam int SYNC_PC_LSB = 16;
  localparam int SYNC_CMP_BIT = 20;
  localparam int CMP_SEL_BIT = 7;
  localparam int DBG_SEL_BIT = 0;
  localparam int CMP_LINE = 7;
  localparam int DBG_LINE = 0;
  localparam int CD_LINE_LSB = 8;
  localparam int POLLED_BIT = 0;
  localparam logic [7:0] SPECIAL_WMASK = 8'h81;
  localparam logic [7:0] CD_WMASK = 8'h0F;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_LINES = 12'h000;
  localparam logic [23:0] RST_PRIORITY = 24'h000000;

  // ----------------------------------------------------------------
  // vector addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_AD_BASE = 8'h30;
  localparam logic [7:0] VEC_CD_BASE = 8'h60;
  localparam logic [7:0] VEC_STEP = 8'h04;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

//--- pis_port_irq_select.sv
// Port-pin interrupt source selector with pending flags, enables, priorities and an AHB-Lite slave.
// Assumes pins arrive asynchronously; debug, DMA and exception requests come from sys_clk logic.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

module pis_port_irq_select
  import pis_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_d_pin,
  input wire logic [3:0] port_c_pin,
  input wire logic comparator_out,
  input wire logic on_chip_debug_channel,
  input wire logic [3:0] dma_request,
  input wire logic system_exception,
  output logic irq,
  output logic [7:0] irq_vector,
  output logic [1:0] irq_level,
  output logic exception_req
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [20:0] sync1;
    logic [20:0] sync2;
    logic [20:0] sync3;
    logic [20:0] stable;
    logic [7:0] special_source_mux;
    logic [7:0] port_a_d_source_select;
    logic [7:0] pin_edge_polarity;
    logic [7:0] port_c_dma_source_select;
    logic [11:0] pending;
    logic [11:0] enable;
    logic [23:0] priority_code;
    logic polled;
    logic wr_pend;
    logic [9:0] wr_sel;
    logic [31:0] rdata;
    logic readyout;
    logic irq;
    logic [7:0] vector;
    logic [1:0] level;
    logic exception;
  } pis_state_t;

  pis_state_t q;
  pis_state_t n;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam int SEL_SPECIAL = 0;
  localparam int SEL_AD = 1;
  localparam int SEL_EDGE = 2;
  localparam int SEL_CD = 3;
  localparam int SEL_STATUS = 4;
  localparam int SEL_CLEAR = 5;
  localparam int SEL_ENABLE = 6;
  localparam int SEL_SOFT = 7;
  localparam int SEL_PRIORITY = 8;
  localparam int SEL_CONTROL = 9;

  function automatic logic [31:0] pis_byte_addr(input logic [31:0] idx);
    pis_byte_addr = {idx[29:0], 2'h0};
  endfunction

  // one-hot register select; all zero means unmapped
  function automatic logic [9:0] pis_decode(input logic [31:0] addr);
    logic [9:0] sel;
    sel = 10'h000;
    sel[SEL_SPECIAL] = (addr == pis_byte_addr(IDX_SPECIAL_MUX));
    sel[SEL_AD] = (addr == pis_byte_addr(IDX_AD_SELECT));
    sel[SEL_EDGE] = (addr == pis_byte_addr(IDX_EDGE_POL));
    sel[SEL_CD] = (addr == pis_byte_addr(IDX_CD_SELECT));
    sel[SEL_STATUS] = (addr == pis_byte_addr(IDX_STATUS));
    sel[SEL_CLEAR] = (addr == pis_byte_addr(IDX_CLEAR));
    sel[SEL_ENABLE] = (addr == pis_byte_addr(IDX_ENABLE));
    sel[SEL_SOFT] = (addr == pis_byte_addr(IDX_SOFT_SET));
    sel[SEL_PRIORITY] = (addr == pis_byte_addr(IDX_PRIORITY));
    sel[SEL_CONTROL] = (addr == pis_byte_addr(IDX_CONTROL));
    return sel;
  endfunction

  // priority code 0 counts as the lowest of the three levels
  function automatic logic [1:0] pis_eff_level(input logic [1:0] code);
    pis_eff_level = (code == 2'h0) ? 2'h1 : code;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [20:0] async_in;
  logic [20:0] toggled;
  logic [20:0] rose;
  logic [7:0] a_edge;
  logic [7:0] d_edge;
  logic [11:0] events;
  logic [11:0] soft_set;
  logic [11:0] clr;
  logic [11:0] active;
  logic [9:0] addr_sel;
  logic take;
  logic found;
  logic [1:0] best_level;
  logic [7:0] best_vector;
  logic [3:0] line;
  logic [1:0] lvl;

  assign async_in = {comparator_out, port_c_pin, port_d_pin, port_a_pin};

  always_comb begin
    n = q;
    soft_set = RST_LINES;
    clr = RST_LINES;
    events = RST_LINES;
    found = 1'b0;
    best_level = 2'h0;
    best_vector = 8'h00;
    line = 4'h0;
    lvl = 2'h0;

    // three-stage pin synchroniser; a level counts once stages two and three agree
    n.sync1 = async_in; // RULE_14
    n.sync2 = q.sync1;
    n.sync3 = q.sync2;
    for (int i = 0; i < NUM_SYNC; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        n.stable[i] = q.sync3[i]; // RULE_14
      end
    end
    toggled = n.stable ^ q.stable;
    rose = n.stable & ~q.stable;

    // edges are found per pin before the A/D mux, so switching the mux cannot fake an edge
    for (int k = 0; k < NUM_AD; k++) begin
      a_edge[k] = q.pin_edge_polarity[k] ? rose[k] : (toggled[k] & ~rose[k]); // RULE_05
      d_edge[k] = q.pin_edge_polarity[k] ? rose[SYNC_PD_LSB + k]
                                         : (toggled[SYNC_PD_LSB + k] & ~rose[SYNC_PD_LSB + k]); // RULE_05
      events[k] = q.port_a_d_source_select[k] ? d_edge[k] : a_edge[k]; // RULE_04 RULE_07
    end
    if (q.special_source_mux[CMP_SEL_BIT]) begin
      events[CMP_LINE] = toggled[SYNC_CMP_BIT]; // RULE_01 RULE_12
    end
    if (q.special_source_mux[DBG_SEL_BIT]) begin
      events[DBG_LINE] = on_chip_debug_channel; // RULE_02
    end
    for (int k = 0; k < NUM_CD; k++) begin
      events[CD_LINE_LSB + k] = q.port_c_dma_source_select[k] ? toggled[SYNC_PC_LSB + k]
                                                              : dma_request[k]; // RULE_06 RULE_13
    end

    // bus: write data phase applies hwdata to the register selected in the address phase
    if (q.wr_pend) begin
      if (q.wr_sel[SEL_SPECIAL]) begin
        n.special_source_mux = hwdata[7:0] & SPECIAL_WMASK; // RULE_03
      end
      if (q.wr_sel[SEL_AD]) begin
        n.port_a_d_source_select = hwdata[7:0];
      end
      if (q.wr_sel[SEL_EDGE]) begin
        n.pin_edge_polarity = hwdata[7:0];
      end
      if (q.wr_sel[SEL_CD]) begin
        n.port_c_dma_source_select = hwdata[7:0] & CD_WMASK; // RULE_06
      end
      if (q.wr_sel[SEL_CLEAR]) begin
        clr = hwdata[11:0];
      end
      if (q.wr_sel[SEL_ENABLE]) begin
        n.enable = hwdata[11:0];
      end
      if (q.wr_sel[SEL_SOFT]) begin
        soft_set = hwdata[11:0]; // RULE_09
      end
      if (q.wr_sel[SEL_PRIORITY]) begin
        n.priority_code = hwdata[23:0]; // RULE_08
      end
      if (q.wr_sel[SEL_CONTROL]) begin
        n.polled = hwdata[POLLED_BIT]; // RULE_11
      end
    end

    // sticky pending flags: a set in the clearing cycle wins
    n.pending = (q.pending & ~clr) | events | soft_set; // RULE_09 RULE_14

    // address phase; read data comes from the next state so a write just before is seen
    take = hsel & hready & htrans[1];
    addr_sel = pis_decode(haddr);
    n.wr_pend = take & hwrite;
    n.wr_sel = addr_sel;
    if (take & ~hwrite) begin
      n.rdata = 32'h0000_0000;
      unique case (1'b1)
        addr_sel[SEL_SPECIAL]: n.rdata[7:0] = n.special_source_mux; // RULE_03
        addr_sel[SEL_AD]: n.rdata[7:0] = n.port_a_d_source_select;
        addr_sel[SEL_EDGE]: n.rdata[7:0] = n.pin_edge_polarity;
        addr_sel[SEL_CD]: n.rdata[7:0] = n.port_c_dma_source_select;
        addr_sel[SEL_STATUS]: n.rdata[11:0] = n.pending; // RULE_11
        addr_sel[SEL_ENABLE]: n.rdata[11:0] = n.enable;
        addr_sel[SEL_PRIORITY]: n.rdata[23:0] = n.priority_code;
        addr_sel[SEL_CONTROL]: n.rdata[POLLED_BIT] = n.polled;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    n.readyout = 1'b1;

    // arbitration over enabled pending lines in fixed vector order: A7..A0 then C3..C0
    active = q.pending & q.enable;
    for (int p = NUM_LINES - 1; p >= 0; p--) begin
      line = (p < NUM_AD) ? 4'(NUM_AD - 1 - p) : 4'(NUM_LINES + CD_LINE_LSB - 1 - p);
      lvl = pis_eff_level(q.priority_code[2 * line +: 2]); // RULE_08
      if (active[line] && (!found || lvl >= best_level)) begin
        found = 1'b1;
        best_level = lvl;
        best_vector = (p < NUM_AD) ? VEC_AD_BASE + 8'(p) * VEC_STEP
                                   : VEC_CD_BASE + 8'(p - NUM_AD) * VEC_STEP; // RULE_12 RULE_13
      end
    end

    // polled mode keeps the request line quiet; flags still collect
    n.irq = found & ~q.polled; // RULE_11
    n.vector = q.polled ? 8'h00 : best_vector; // RULE_11
    n.level = q.polled ? 2'h0 : best_level;
    n.exception = system_exception; // RULE_10
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q.sync1 <= '0;
      q.sync2 <= '0;
      q.sync3 <= '0;
      q.stable <= '0;
      q.special_source_mux <= RST_BYTE;
      q.port_a_d_source_select <= RST_BYTE;
      q.pin_edge_polarity <= RST_BYTE;
      q.port_c_dma_source_select <= RST_BYTE;
      q.pending <= RST_LINES;
      q.enable <= RST_LINES;
      q.priority_code <= RST_PRIORITY;
      q.polled <= 1'b0;
      q.wr_pend <= 1'b0;
      q.wr_sel <= 10'h000;
      q.rdata <= 32'h0000_0000;
      q.readyout <= 1'b1;
      q.irq <= 1'b0;
      q.vector <= 8'h00;
      q.level <= 2'h0;
      q.exception <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = q.readyout;
  assign hresp = 1'b0;
  assign irq = q.irq;
  assign irq_vector = q.vector;
  assign irq_level = q.level;
  assign exception_req = q.exception;

endmodule // pis_port_irq_select

//--- pis_cpu_model.sv
// Far-side model: the CPU core that takes the selector's request and vector.
// Assumes irq and irq_vector are registered outputs on sys_clk.
`timescale 1ns/1ps
module pis_cpu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic irq,
  input wire logic [7:0] irq_vector,
  output logic [7:0] seen_vector
);
  // ----
  // vector capture
  // ----
  // the core only fetches a vector while the request stands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_vector <= 8'h00;
    end else if (irq) begin
      seen_vector <= irq_vector;
    end
  end
endmodule // pis_cpu_model

//--- pis_properties.sv
// Checker on the selector's top-level ports.
// Assumes one sys_clk domain and the bind at the foot of this file.
`timescale 1ns/1ps
module pis_properties
  import pis_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic system_exception,
  input wire logic irq,
  input wire logic [7:0] irq_vector,
  input wire logic [1:0] irq_level,
  input wire logic exception_req
);
  // ----
  // properties
  // ----
  localparam logic [31:0] A_SPC = IDX_SPECIAL_MUX << 2;
  localparam logic [31:0] A_CD = IDX_CD_SELECT << 2;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_at(a);
    hsel && hready && htrans[1] && !hwrite && haddr == a;
  endsequence
  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  hresp_okay_a: assert property (!hresp) else $error("error response");
  exc_follow_a: assert property (system_exception |=> exception_req) else $error("exception lost");
  exc_drop_a: assert property (!system_exception |=> !exception_req) else $error("exception stuck");
  irq_quiet_a: assert property (!irq |-> irq_vector == 8'h00 && irq_level == 2'h0)
    else $error("vector without request");
  vec_range_a: assert property (irq |-> irq_vector[1:0] == 2'h0 &&
    irq_vector inside {[8'h30:8'h4C], [8'h60:8'h6C]}) else $error("bad vector");
  level_set_a: assert property (irq |-> irq_level != 2'h0) else $error("no level");
  spc_rsvd_a: assert property (rd_at(A_SPC) |=> hrdata[31:1] == 31'h0 ||
    hrdata[31:8] == 24'h0 && hrdata[6:1] == 6'h00) else $error("reserved bits set");
  cd_rsvd_a: assert property (rd_at(A_CD) |=> hrdata[31:4] == 28'h0) else $error("reserved bits set");
endmodule // pis_properties

bind pis_port_irq_select pis_properties u_props (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .system_exception, .irq, .irq_vector, .irq_level, .exception_req);

//--- test_port_irq_source_select.sv
// Self-checking bench for the selector: random config, pin edges, pulses, irq winner.
// Assumes pis_pkg, the design, the checker bind and the CPU model are compiled first.
`timescale 1ns/1ps
module test_port_irq_source_select import pis_pkg::*; ;
  // ----
  // stimulus and model state
  // ----
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, comparator_out = 0, on_chip_debug_channel = 0;
  logic system_exception = 0, hreadyout, hresp, irq, exception_req;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, irq_level;
  logic [2:0] hsize = 3'h2;
  logic [7:0] port_a_pin = 0, port_d_pin = 0, irq_vector, seen_vector, sel, edg, spc;
  logic [3:0] port_c_pin = 0, dma_request = 0, cd;
  logic [11:0] pend = 0, en, s;
  logic [23:0] pri;
  int err_total = 0, tests_run = 0;
  localparam logic [31:0] A_SPC = IDX_SPECIAL_MUX << 2, A_AD = IDX_AD_SELECT << 2, A_EDG = IDX_EDGE_POL << 2;
  localparam logic [31:0] A_CD = IDX_CD_SELECT << 2, A_ST = IDX_STATUS << 2, A_CLR = IDX_CLEAR << 2;
  localparam logic [31:0] A_EN = IDX_ENABLE << 2, A_SET = IDX_SOFT_SET << 2, A_PRI = IDX_PRIORITY << 2;
  localparam logic [31:0] A_CTL = IDX_CONTROL << 2, A_BAD = 32'h0000_1000;
  logic [31:0] regs [8] = '{A_SPC, A_AD, A_EDG, A_CD, A_ST, A_EN, A_PRI, A_CTL};
  always #50 sys_clk = ~sys_clk;
  pis_port_irq_select dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .port_a_pin, .port_d_pin, .port_c_pin, .comparator_out, .on_chip_debug_channel,
    .dma_request, .system_exception, .irq, .irq_vector, .irq_level, .exception_req);
  pis_cpu_model cpu (.sys_clk, .rst, .irq, .irq_vector, .seen_vector);
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    $display("mismatches %0d, comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic pins(input logic [7:0] na, nd, input logic [3:0] nc, input logic nm);
    logic o, n;
    for (int k = 0; k < 8; k++) begin
      o = sel[k] ? port_d_pin[k] : port_a_pin[k];
      n = sel[k] ? nd[k] : na[k];
      if (!(k == 7 && spc[7]) && !(k == 0 && spc[0]) && o != n && n == edg[k]) pend[k] = 1'b1;
    end
    if (spc[7] && nm != comparator_out) pend[7] = 1'b1;
    for (int k = 0; k < 4; k++) if (cd[k] && nc[k] != port_c_pin[k]) pend[8+k] = 1'b1;
    port_a_pin <= na;
    port_d_pin <= nd;
    port_c_pin <= nc;
    comparator_out <= nm;
    repeat (8) @(posedge sys_clk);
    bus(A_ST, 0, 0);
    chk("pin status", pend, rd);
  endtask
  // winner: highest level, ties to the lower vector address
  task automatic irqchk;
    int b, bl, l, k;
    logic [7:0] v;
    b = -1;
    bl = 0;
    for (int i = 0; i < 12; i++) begin
      k = i < 8 ? 7 - i : 19 - i;
      l = pri[2*k+:2] == 2'h0 ? 1 : int'(pri[2*k+:2]);
      if (pend[k] && en[k] && l > bl) begin
        b = k;
        bl = l;
      end
    end
    v = b < 0 ? 8'h00 : b < 8 ? 8'h30 + 8'(4 * (7 - b)) : 8'h60 + 8'(4 * (11 - b));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", b >= 0, irq);
    chk("vector", v, irq_vector);
    chk("level", bl, irq_level);
    if (b >= 0) chk("cpu vector", v, seen_vector);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h0A6A));
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    foreach (regs[i]) begin
      bus(regs[i], 0, 0);
      chk("reset value", 32'h0, rd);
    end
    bus(A_BAD, 1, 32'hFFFF_FFFF);
    bus(A_BAD, 0, 0);
    chk("unmapped", 32'h0, rd);
    repeat (12) begin
      {sel, edg, spc} = 24'($urandom);
      {cd, en} = 16'($urandom);
      pri = 24'($urandom);
      bus(A_SPC, 1, {24'hFF_FFFF, spc});
      bus(A_SPC, 0, 0);
      spc = spc & SPECIAL_WMASK;
      chk("special mux", {24'h0, spc}, rd);
      bus(A_AD, 1, {24'h0, sel});
      bus(A_EDG, 1, {24'h0, edg});
      bus(A_CD, 1, {28'hFFF_FFFF, cd});
      bus(A_CD, 0, 0);
      chk("c dma select", {28'h0, cd}, rd);
      bus(A_AD, 0, 0);
      chk("ad select", {24'h0, sel}, rd);
      bus(A_EN, 1, {20'h0, en});
      bus(A_PRI, 1, {8'h0, pri});
      bus(A_CLR, 1, 32'h0000_0FFF);
      pend = 12'h000;
      repeat (3) pins(8'($urandom), 8'($urandom), 4'($urandom), 1'($urandom));
      @(posedge sys_clk);
      on_chip_debug_channel <= 1'b1;
      dma_request <= 4'($urandom);
      @(posedge sys_clk);
      if (spc[0]) pend[0] = 1'b1;
      pend[11:8] = pend[11:8] | (dma_request & ~cd);
      on_chip_debug_channel <= 1'b0;
      dma_request <= 4'h0;
      bus(A_ST, 0, 0);
      chk("pulse status", pend, rd);
      irqchk();
      bus(A_CTL, 1, 32'h1);
      irqchk_polled();
      bus(A_CTL, 1, 32'h0);
      s = 12'($urandom);
      pend = pend | s;
      bus(A_SET, 1, {20'h0, s});
      irqchk();
    end
    @(posedge sys_clk);
    system_exception <= 1'b1;
    @(posedge sys_clk);
    system_exception <= 1'b0;
    @(negedge sys_clk);
    chk("exception", 32'h1, exception_req);
    results();
  end
  task automatic irqchk_polled;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("polled irq", 32'h0, irq);
    bus(A_ST, 0, 0);
    chk("polled status", pend, rd);
  endtask
endmodule // test_port_irq_source_select
